/* File: logic/can_cfg.svh */
// Summary of operation
// (R1) read request 0x04 answers 0x04, port count
// (R2) one full record follows per port
// (R3) 21-byte record: port, rate, format, ids
// (R4) bit rate limited to eight listed values
// (R5) format 0 standard, 1 extended identifiers
// (R6) detections per message limited 1 to 96
// (R7) inter-message gap in milliseconds, two bytes
// (R8) inter-cycle gap in milliseconds, two bytes
// (R9) write request 0x05, answer only 0x05
// (R10) record applies to port in byte 0
// (R11) host may send several tagged records
// (R12) invalid record leaves port settings unchanged
`ifndef CAN_CFG_SVH
`define CAN_CFG_SVH

`define FUNC_CODE      8'h45
`define SUB_READ       8'h04
`define SUB_WRITE      8'h05
`define REC_BYTES      21
`define REC_LAST_IDX   5'h14
`define OFF_PORT       0
`define OFF_RATE       1
`define OFF_FMT        5
`define OFF_TXID       6
`define OFF_RXID       10
`define OFF_MAXDET     14
`define OFF_RES        15
`define OFF_IMD        17
`define OFF_ICD        19
`define FMT_STD        8'h00
`define FMT_EXT        8'h01
`define MAXDET_MIN     8'h01
`define MAXDET_MAX     8'h60
`define RATE_10K       32'h0000_2710
`define RATE_20K       32'h0000_4E20
`define RATE_50K       32'h0000_C350
`define RATE_100K      32'h0001_86A0
`define RATE_125K      32'h0001_E848
`define RATE_250K      32'h0003_D090
`define RATE_500K      32'h0007_A120
`define RATE_1M        32'h000F_4240
`define RST_RATE       32'h000F_4240
`define RST_FMT        8'h00
`define RST_TXID       32'h0000_0750
`define RST_RXID       32'h0000_0740
`define RST_MAXDET     8'h60
`define RST_RES        16'h0001
`define RST_DELAY      16'h0000
`define MS_NS          1000000
`define CLK_PERIOD_NS  8
`define CYCLES_PER_MS  (`MS_NS / `CLK_PERIOD_NS)

`endif

/* File: logic/can_cfg_pkg.sv */
`include "can_cfg.svh"
`default_nettype none
package can_cfg_pkg;
	typedef enum logic [2:0] {
		S_FUNC,
		S_SUB,
		S_REC,
		S_APPLY,
		S_DRAIN,
		S_TX
	} cmd_state_type;
	typedef logic [`REC_BYTES*8-1:0] record_type;
endpackage
`default_nettype wire

/* File: logic/record_checker.sv */
`include "can_cfg.svh"
`default_nettype none
module record_checker
	import can_cfg_pkg::*;
(
	input  wire record_type rec,
	output logic            recOk
);
	logic [31:0] rate;
	logic [7:0]  fmt;
	logic [7:0]  maxDet;
	logic        rateOk;

	assign rate   = rec[8*`OFF_RATE +: 32];
	assign fmt    = rec[8*`OFF_FMT +: 8];
	assign maxDet = rec[8*`OFF_MAXDET +: 8];

	always_comb begin
		rateOk = 1'b0;
		case (rate) // R4
			`RATE_10K, `RATE_20K, `RATE_50K, `RATE_100K,
			`RATE_125K, `RATE_250K, `RATE_500K, `RATE_1M: rateOk = 1'b1;
			default: rateOk = 1'b0;
		endcase
	end

	assign recOk = rateOk && (fmt == `FMT_STD || fmt == `FMT_EXT) // R5 R12
		&& maxDet >= `MAXDET_MIN && maxDet <= `MAXDET_MAX; // R6
endmodule
`default_nettype wire

/* File: logic/gap_timer.sv */
`include "can_cfg.svh"
`default_nettype none
module gap_timer (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        msTick,
	input  wire logic        start,
	input  wire logic [15:0] delayMs,
	output logic             busy
);
	logic [15:0] count_reg;

	// gap runs between delayMs-1 and delayMs ms since the tick is free running
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= 16'h0000;
			busy      <= 1'b0;
		end else if (start) begin
			count_reg <= delayMs;
			busy      <= (delayMs != 16'h0000);
		end else if (busy && msTick) begin
			count_reg <= count_reg - 16'h0001;
			if (count_reg == 16'h0001) begin
				busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: logic/can_port_settings_cmd.sv */
`include "can_cfg.svh"
`default_nettype none
module can_port_settings_cmd
	import can_cfg_pkg::*;
#(
	parameter int CAN_PORTS  = 1,
	parameter int MS_CYCLES  = `CYCLES_PER_MS
) (
	input  wire logic                        sys_clk,
	input  wire logic                        rst_b,
	input  wire logic [7:0]                  rxData,
	input  wire logic                        rxValid,
	input  wire logic                        rxLast,
	output logic                             rxReady,
	output logic [7:0]                       txData,
	output logic                             txValid,
	output logic                             txLast,
	input  wire logic                        txReady,
	input  wire logic [CAN_PORTS-1:0]        msgSent,
	input  wire logic [CAN_PORTS-1:0]        cycleDone,
	output logic [CAN_PORTS-1:0][31:0]       canBitRate,
	output logic [CAN_PORTS-1:0][7:0]        canFrameFormat,
	output logic [CAN_PORTS-1:0][31:0]       canTxBaseId,
	output logic [CAN_PORTS-1:0][31:0]       canRxBaseId,
	output logic [CAN_PORTS-1:0][7:0]        canMaxDetections,
	output logic [CAN_PORTS-1:0][15:0]       canDistRes,
	output logic [CAN_PORTS-1:0][15:0]       canMsgDelay,
	output logic [CAN_PORTS-1:0][15:0]       canCycleDelay,
	output logic [CAN_PORTS-1:0]             msgGapBusy,
	output logic [CAN_PORTS-1:0]             cycleGapBusy
);
	localparam int READ_LAST = 2 + `REC_BYTES * CAN_PORTS - 1;

	cmd_state_type state_reg;
	cmd_state_type state_next;
	record_type    recBuf_reg;
	record_type    txRec;
	logic [4:0]    recIdx_reg;
	logic          lastSeen_reg;
	logic [7:0]    sub_reg;
	logic [7:0]    subNow;
	logic          rxAccept;
	logic          txAccept;
	logic          recOk;
	logic [7:0]    recPort;
	logic [1:0]    txPhase_reg;
	logic [7:0]    txPort_reg;
	logic [4:0]    txOff_reg;
	logic [7:0]    nextPort;
	logic [4:0]    nextOff;
	logic [15:0]   txBytes_reg;
	logic [31:0]   msCnt_reg;
	logic          msTick;

	assign rxAccept = rxValid && rxReady;
	assign txAccept = txValid && txReady;
	assign recPort  = recBuf_reg[8*`OFF_PORT +: 8];
	assign subNow   = (state_reg == S_SUB) ? rxData : sub_reg;

	record_checker u_checker (
		.rec   (recBuf_reg),
		.recOk (recOk)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_FUNC: begin
				if (rxAccept && !rxLast) begin
					state_next = (rxData == `FUNC_CODE) ? S_SUB : S_DRAIN;
				end
			end
			S_SUB: begin
				if (rxAccept) begin
					if (rxData == `SUB_READ || rxData == `SUB_WRITE) begin // R1 R9
						if (rxLast) begin
							state_next = S_TX;
						end else begin
							state_next = (rxData == `SUB_WRITE) ? S_REC : S_DRAIN;
						end
					end else begin
						state_next = rxLast ? S_FUNC : S_DRAIN;
					end
				end
			end
			S_REC: begin
				if (rxAccept) begin
					if (recIdx_reg == `REC_LAST_IDX) begin
						state_next = S_APPLY;
					end else if (rxLast) begin
						// a short trailing fragment is dropped, the write is still answered
						state_next = S_TX;
					end
				end
			end
			S_APPLY: begin
				state_next = lastSeen_reg ? S_TX : S_REC; // R11
			end
			S_DRAIN: begin
				if (rxAccept && rxLast) begin
					state_next = (sub_reg == `SUB_READ || sub_reg == `SUB_WRITE) ? S_TX : S_FUNC;
				end
			end
			S_TX: begin
				if (txAccept && txLast) begin
					state_next = S_FUNC;
				end
			end
			default: state_next = S_FUNC;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= S_FUNC;
			rxReady   <= 1'b0;
		end else begin
			state_reg <= state_next;
			// no input is taken while a record is applied or an answer is out
			rxReady   <= (state_next != S_APPLY) && (state_next != S_TX);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sub_reg <= 8'h00;
		end else if (rxAccept && state_reg == S_FUNC) begin
			sub_reg <= 8'h00;
		end else if (rxAccept && state_reg == S_SUB) begin
			sub_reg <= rxData;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			recBuf_reg   <= '0;
			recIdx_reg   <= 5'h00;
			lastSeen_reg <= 1'b0;
		end else if (state_reg == S_SUB || state_reg == S_APPLY) begin
			recIdx_reg <= 5'h00;
		end else if (state_reg == S_REC && rxAccept) begin
			recBuf_reg[recIdx_reg*8 +: 8] <= rxData;
			recIdx_reg   <= recIdx_reg + 5'h01;
			lastSeen_reg <= rxLast;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			msCnt_reg <= 32'h0000_0000;
			msTick    <= 1'b0;
		end else if (msCnt_reg == 32'(MS_CYCLES - 1)) begin
			msCnt_reg <= 32'h0000_0000;
			msTick    <= 1'b1;
		end else begin
			msCnt_reg <= msCnt_reg + 32'h0000_0001;
			msTick    <= 1'b0;
		end
	end

	for (genvar p = 0; p < CAN_PORTS; p++) begin : g_port
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				canBitRate[p]       <= `RST_RATE;
				canFrameFormat[p]   <= `RST_FMT;
				canTxBaseId[p]      <= `RST_TXID;
				canRxBaseId[p]      <= `RST_RXID;
				canMaxDetections[p] <= `RST_MAXDET;
				canDistRes[p]       <= `RST_RES;
				canMsgDelay[p]      <= `RST_DELAY;
				canCycleDelay[p]    <= `RST_DELAY;
			end else if (state_reg == S_APPLY && recOk && recPort == 8'(p)) begin // R10 R12
				canBitRate[p]       <= recBuf_reg[8*`OFF_RATE +: 32]; // R3
				canFrameFormat[p]   <= recBuf_reg[8*`OFF_FMT +: 8];
				canTxBaseId[p]      <= recBuf_reg[8*`OFF_TXID +: 32];
				canRxBaseId[p]      <= recBuf_reg[8*`OFF_RXID +: 32];
				canMaxDetections[p] <= recBuf_reg[8*`OFF_MAXDET +: 8];
				canDistRes[p]       <= recBuf_reg[8*`OFF_RES +: 16];
				canMsgDelay[p]      <= recBuf_reg[8*`OFF_IMD +: 16];
				canCycleDelay[p]    <= recBuf_reg[8*`OFF_ICD +: 16];
			end
		end

		gap_timer u_msgGap (
			.sys_clk (sys_clk),
			.rst_b   (rst_b),
			.msTick  (msTick),
			.start   (msgSent[p]),
			.delayMs (canMsgDelay[p]), // R7
			.busy    (msgGapBusy[p])
		);

		gap_timer u_cycleGap (
			.sys_clk (sys_clk),
			.rst_b   (rst_b),
			.msTick  (msTick),
			.start   (cycleDone[p]),
			.delayMs (canCycleDelay[p]), // R8
			.busy    (cycleGapBusy[p])
		);
	end

	// same byte layout on the way out as on the way in
	always_comb begin
		txRec = '0;
		for (int p = 0; p < CAN_PORTS; p++) begin
			if (nextPort == 8'(p)) begin
				txRec = {canCycleDelay[p], canMsgDelay[p], canDistRes[p],
					canMaxDetections[p], canRxBaseId[p], canTxBaseId[p],
					canFrameFormat[p], canBitRate[p], 8'(p)}; // R3
			end
		end
	end

	always_comb begin
		nextPort = 8'h00;
		nextOff  = 5'h00;
		if (txPhase_reg == 2'h2) begin
			if (txOff_reg == `REC_LAST_IDX) begin
				nextPort = txPort_reg + 8'h01;
			end else begin
				nextPort = txPort_reg;
				nextOff  = txOff_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txValid     <= 1'b0;
			txData      <= 8'h00;
			txLast      <= 1'b0;
			txPhase_reg <= 2'h0;
			txPort_reg  <= 8'h00;
			txOff_reg   <= 5'h00;
		end else if (state_reg != S_TX && state_next == S_TX) begin
			txValid     <= 1'b1;
			txData      <= subNow; // R1 R9
			txLast      <= (subNow == `SUB_WRITE);
			txPhase_reg <= 2'h0;
		end else if (txAccept) begin
			if (txLast) begin
				txValid <= 1'b0;
				txLast  <= 1'b0;
			end else if (txPhase_reg == 2'h0) begin
				txData      <= 8'(CAN_PORTS); // R1
				txPhase_reg <= 2'h1;
			end else begin
				txData      <= txRec[nextOff*8 +: 8]; // R2
				txPort_reg  <= nextPort;
				txOff_reg   <= nextOff;
				txPhase_reg <= 2'h2;
				txLast      <= (nextPort == 8'(CAN_PORTS - 1)) && (nextOff == `REC_LAST_IDX);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txBytes_reg <= 16'h0000;
		end else if (state_reg != S_TX) begin
			txBytes_reg <= 16'h0000;
		end else if (txAccept) begin
			txBytes_reg <= txBytes_reg + 16'h0001;
		end
	end

	logic [31:0] recRateView;
	assign recRateView = recBuf_reg[8*`OFF_RATE +: 32];

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence seqReadSubTaken;
		txAccept && txPhase_reg == 2'h0 && txData == `SUB_READ && !txLast;
	endsequence

	sequence seqCountShown;
		txValid && txPhase_reg == 2'h1 && txData == 8'(CAN_PORTS);
	endsequence

	AST_READ_HEADER: assert property ( // R1
		seqReadSubTaken |=> seqCountShown
	) else $error("port count does not follow read answer code");

	AST_RECORD_COUNT: assert property ( // R2
		txAccept && txLast && txPhase_reg == 2'h2 |-> txBytes_reg == 16'(READ_LAST)
	) else $error("read answer length wrong");

	AST_RECORD_PORT_BYTE: assert property ( // R3
		txValid && txPhase_reg == 2'h2 && txOff_reg == 5'h00 |-> txData == txPort_reg
	) else $error("record does not open with its port number");

	AST_RATE_SUPPORTED: assert property ( // R4
		canBitRate[0] inside {`RATE_10K, `RATE_20K, `RATE_50K, `RATE_100K,
			`RATE_125K, `RATE_250K, `RATE_500K, `RATE_1M}
	) else $error("unsupported bit rate stored");

	AST_FORMAT_LEGAL: assert property ( // R5
		canFrameFormat[0] == `FMT_STD || canFrameFormat[0] == `FMT_EXT
	) else $error("illegal frame format stored");

	AST_DETECTIONS_RANGE: assert property ( // R6
		canMaxDetections[0] >= `MAXDET_MIN && canMaxDetections[0] <= `MAXDET_MAX
	) else $error("detection limit out of range");

	AST_MSG_GAP_START: assert property ( // R7
		msgSent[0] && canMsgDelay[0] != 16'h0000 |=> msgGapBusy[0]
	) else $error("inter-message gap not started");

	AST_CYCLE_GAP_END: assert property ( // R8
		$fell(cycleGapBusy[0]) && !$past(cycleDone[0]) |-> $past(msTick)
	) else $error("inter-cycle gap ended off a millisecond tick");

	AST_WRITE_ACK: assert property ( // R9
		txValid && txPhase_reg == 2'h0 && txData == `SUB_WRITE |-> txLast
	) else $error("write answer longer than one byte");

	AST_APPLY_PORT: assert property ( // R10
		state_reg == S_APPLY && recOk && recPort == 8'h00 |=> canBitRate[0] == $past(recRateView)
	) else $error("record not applied to its port");

	AST_REJECT_KEEPS: assert property ( // R12
		state_reg == S_APPLY && !recOk |=> $stable(canBitRate) && $stable(canMaxDetections)
	) else $error("invalid record changed stored settings");
endmodule
`default_nettype wire

/* File: bench/can_host_model.sv */
`default_nettype none
module can_host_model (
	input  wire logic       sys_clk,
	output logic [7:0]      rxData,
	output logic            rxValid,
	output logic            rxLast,
	input  wire logic       rxReady,
	input  wire logic [7:0] txData,
	input  wire logic       txValid,
	input  wire logic       txLast,
	output logic            txReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	logic       lst[$];
	bit         stall = 0;
	int         tick = 0;
	initial begin
		rxData = 8'h00;
		rxValid = 1'b0;
		rxLast = 1'b0;
		txReady = 1'b1;
	end
	// a stalling sink takes two cycles out of four, like a slow host
	always @(posedge sys_clk) begin
		if (txValid === 1'b1 && txReady === 1'b1) begin
			got.push_back(txData);
			lst.push_back(txLast);
		end
		tick++;
		#1;
		txReady = !stall || tick[1];
	end
	// bytes held until taken; released data shows garbage, not the last byte
	task automatic send(input logic [7:0] fr[$], output bit ok);
		int n = 0;
		@(posedge sys_clk);
		foreach (fr[i]) begin
			#1;
			rxData = fr[i];
			rxValid = 1'b1;
			rxLast = (i == fr.size() - 1);
			do begin
				@(posedge sys_clk);
				n++;
			end while (rxReady !== 1'b1 && n < 2000);
		end
		#1;
		rxValid = 1'b0;
		rxLast = 1'b0;
		rxData = ~rxData;
		ok = n < 2000;
	endtask
endmodule
`default_nettype wire

/* File: bench/can_port_settings_cmd_tb_top.sv */
`include "can_cfg.svh"
`default_nettype none
module can_port_settings_cmd_tb_top
	import can_cfg_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic             sys_clk = 1'b0;
	logic             rst_b = 1'b0;
	logic [7:0]       rxData, txData;
	logic             rxValid, rxLast, rxReady, txValid, txLast, txReady;
	logic [1:0]       msgSent = 2'h0, cycleDone = 2'h0, msgGapBusy, cycleGapBusy;
	logic [1:0][31:0] canBitRate, canTxBaseId, canRxBaseId;
	logic [1:0][7:0]  canFrameFormat, canMaxDetections;
	logic [1:0][15:0] canDistRes, canMsgDelay, canCycleDelay;
	logic [31:0]      eRate[2] = '{`RST_RATE, `RST_RATE};
	logic [31:0]      eTx[2] = '{`RST_TXID, `RST_TXID};
	logic [31:0]      eRx[2] = '{`RST_RXID, `RST_RXID};
	logic [7:0]       eFmt[2] = '{`RST_FMT, `RST_FMT};
	logic [7:0]       eDet[2] = '{`RST_MAXDET, `RST_MAXDET};
	logic [15:0]      eRes[2] = '{`RST_RES, `RST_RES};
	logic [15:0]      eImd[2] = '{`RST_DELAY, `RST_DELAY};
	logic [15:0]      eIcd[2] = '{`RST_DELAY, `RST_DELAY};
	logic [7:0]       q[$];
	int               errors = 0;
	int               compares = 0;
	always #4 sys_clk = ~sys_clk;
	// ms shortened to 10 cycles so gaps stay short
	can_port_settings_cmd #(.CAN_PORTS(2), .MS_CYCLES(10)) i_dut (
		.sys_clk, .rst_b, .rxData, .rxValid, .rxLast, .rxReady, .txData, .txValid,
		.txLast, .txReady, .msgSent, .cycleDone, .canBitRate, .canFrameFormat,
		.canTxBaseId, .canRxBaseId, .canMaxDetections, .canDistRes, .canMsgDelay,
		.canCycleDelay, .msgGapBusy, .cycleGapBusy);
	can_host_model i_host (
		.sys_clk, .rxData, .rxValid, .rxLast, .rxReady, .txData, .txValid, .txLast,
		.txReady);
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	function automatic void le(input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++)
			q.push_back(v[8*i+:8]);
	endfunction
	// pushes one record; rx id is always tx id plus 0x10, resolution always 10
	function automatic void add(input logic [7:0] p, input logic [31:0] rt,
		input logic [7:0] fm, input logic [31:0] tx, input logic [7:0] dt,
		input logic [15:0] gm, input logic [15:0] gc, input bit ok);
		q.push_back(p);
		le(rt, 4);
		q.push_back(fm);
		le(tx, 4);
		le(tx + 32'h0000_0010, 4);
		q.push_back(dt);
		le(32'h0000_000A, 2);
		le(gm, 2);
		le(gc, 2);
		if (ok) begin
			eRate[p] = rt;
			eFmt[p] = fm;
			eTx[p] = tx;
			eRx[p] = tx + 32'h0000_0010;
			eDet[p] = dt;
			eRes[p] = 16'h000A;
			eImd[p] = gm;
			eIcd[p] = gc;
		end
	endfunction
	task automatic ports();
		for (int p = 0; p < 2; p++) begin
			check("rate", canBitRate[p], eRate[p]);
			check("format", canFrameFormat[p], eFmt[p]);
			check("tx id", canTxBaseId[p], eTx[p]);
			check("rx id", canRxBaseId[p], eRx[p]);
			check("max det", canMaxDetections[p], eDet[p]);
			check("res", canDistRes[p], eRes[p]);
			check("msg gap", canMsgDelay[p], eImd[p]);
			check("cycle gap", canCycleDelay[p], eIcd[p]);
		end
	endtask
	task automatic frame(input int n);
		bit ok;
		int k;
		i_host.got.delete();
		i_host.lst.delete();
		i_host.send(q, ok);
		check("request taken", ok, 1);
		if (!ok)
			stop_test();
		for (k = 0; k < 300 && i_host.got.size() < n; k++)
			@(posedge sys_clk);
		repeat (30) @(posedge sys_clk);
		check("answer length", i_host.got.size(), n);
		if (k >= 300)
			stop_test();
	endtask
	task automatic wr();
		frame(1);
		check("write answer", i_host.got[0], `SUB_WRITE);
		check("write last", i_host.lst[0], 1);
		ports();
	endtask
	task automatic t_write();
		q = {`FUNC_CODE, `SUB_WRITE};
		add(8'h01, `RATE_125K, `FMT_EXT, 32'h1ABC_DEF0, 8'h60, 16'h0003, 16'hFFFF, 1);
		add(8'h00, `RATE_10K, `FMT_STD, 32'h0000_07FF, 8'h01, 16'h0002, 16'h0001, 1);
		wr();
	endtask
	task automatic t_rates();
		logic [31:0] rt[8] = '{`RATE_10K, `RATE_20K, `RATE_50K, `RATE_100K, `RATE_125K,
			`RATE_250K, `RATE_500K, `RATE_1M};
		for (int i = 0; i < 8; i++) begin
			q = {`FUNC_CODE, `SUB_WRITE};
			add(8'h00, rt[i], `FMT_STD, 32'h0000_0100 + i, 8'h01, 16'h0002, 16'h0001, 1);
			wr();
		end
	endtask
	// the first four bad records target port 1, which must keep its settings; the last targets absent port 2
	task automatic t_bad();
		q = {`FUNC_CODE, `SUB_WRITE};
		add(8'h01, 32'h0000_2711, `FMT_STD, 32'h0000_0001, 8'h10, 16'h0000, 16'h0000, 0);
		add(8'h01, `RATE_50K, 8'h02, 32'h0000_0002, 8'h10, 16'h0000, 16'h0000, 0);
		add(8'h01, `RATE_50K, `FMT_STD, 32'h0000_0003, 8'h00, 16'h0000, 16'h0000, 0);
		add(8'h01, `RATE_50K, `FMT_STD, 32'h0000_0004, 8'h61, 16'h0000, 16'h0000, 0);
		add(8'h02, `RATE_50K, `FMT_STD, 32'h0000_0005, 8'h10, 16'h0000, 16'h0000, 0);
		wr();
	endtask
	task automatic t_read();
		i_host.stall = 1;
		q = {`FUNC_CODE, `SUB_READ};
		frame(44);
		q = {`SUB_READ, 8'h02};
		for (int p = 0; p < 2; p++)
			add(p[7:0], eRate[p], eFmt[p], eTx[p], eDet[p], eImd[p], eIcd[p], 0);
		foreach (q[i])
			check("read byte", i_host.got[i], q[i]);
		check("early last", i_host.lst[42], 0);
		check("read last", i_host.lst[43], 1);
		i_host.stall = 0;
	endtask
	task automatic t_refuse();
		q = {8'h46, `SUB_READ};
		frame(0);
		q = {`FUNC_CODE, 8'h06, 8'h00};
		frame(0);
	endtask
	// a bare write is answered, a trailing fragment is dropped, a padded read answers
	task automatic t_extra();
		q = {`FUNC_CODE, `SUB_WRITE};
		wr();
		q = {`FUNC_CODE, `SUB_WRITE};
		add(8'h01, `RATE_250K, `FMT_STD, 32'h0000_0123, 8'h20, 16'h0004, 16'h0005, 1);
		q.push_back(8'h01);
		q.push_back(8'h00);
		wr();
		q = {`FUNC_CODE, `SUB_READ, 8'h00};
		frame(44);
		check("padded read", i_host.got[0], `SUB_READ);
		check("padded last", i_host.lst[43], 1);
	endtask
	// port 0 only: port 1 must stay idle
	task automatic gap(input bit w, input int ms);
		int n;
		@(posedge sys_clk);
		#1;
		msgSent = {1'b0, !w};
		cycleDone = {1'b0, w};
		@(posedge sys_clk);
		#1;
		msgSent = 2'h0;
		cycleDone = 2'h0;
		check("gap start", w ? cycleGapBusy : msgGapBusy, 2'h1);
		for (n = 0; n < 100 && (w ? cycleGapBusy[0] : msgGapBusy[0]) === 1'b1; n++) begin
			@(posedge sys_clk);
			#1;
		end
		check("gap short", n >= (ms - 1) * 10 + 1, 1);
		check("gap long", n <= ms * 10, 1);
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		ports();
		t_write();
		t_rates();
		t_bad();
		t_read();
		t_refuse();
		t_extra();
		gap(0, 2);
		gap(1, 1);
		stop_test();
	end
endmodule
`default_nettype wire
